// ### rtl/spe_top.sv
// serial programming executive: link shifter, mode entry and command sequencer
//
// Behaviour
// - commands and data move serially, clocked by the clock pin on data pin.
// - unused general pins go high-impedance for the whole programming session.
// - serial output pin one toggles while programming is in progress.
// - read commands for code memory, and for eeprom, config and id.
// - row program for code and eeprom, config program; each verifies its write.
// - bulk erase by segment, plus separate eeprom and code erase commands.
// - blank query, version query and sanity check are answered.
// - bulk erase leaves every erased bit at one.
// - executive uses no user code memory or eeprom for itself.
// - scratch state is free to use and undefined after a session.
// - bulk erase select 3 erases code, eeprom and code-protect bits.
// - blank query answers either blank or not blank.
`timescale 1ns/1ps
module spe_top #(
	parameter int IDX_W = 5,
	parameter logic [15:0] DEV_ID = 16'h5a01,  // arbitrary value
	parameter logic [15:0] APP_ID = 16'h00c3   // arbitrary value
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic PROG_CLOCK_PIN_I,
	input wire logic PROG_DATA_PIN_I,
	output logic PROG_DATA_PIN_O,
	output logic PROG_DATA_PIN_OE_O,
	input wire logic MASTER_CLEAR_HV_PIN_I,
	output logic SERIAL_OUT_PIN_ONE_O,
	output logic UNUSED_PINS_HIZ_O
);
	import spe_pkg::*;

	localparam int AW = IDX_W + 2;
	localparam logic [IDX_W-1:0] IDX_ONES = '1;
	localparam logic [IDX_W-1:0] IDX_CP = IDX_W'(CFG_CP_IDX);
	localparam logic [ROW_LG-1:0] ROW_ONES = '1;
	localparam logic [ROW_LG-1:0] ROW_ZERO = '0;

	// ==========================================================
	// pin synchronisers and mode entry (system clock)
	logic mclr_s1_q, mclr_s2_q, mclr_s3_q;
	logic pgc_s1_q, pgc_s2_q, pgd_s1_q, pgd_s2_q;
	logic mode_q;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			{mclr_s1_q, mclr_s2_q, mclr_s3_q} <= 3'h0;
			{pgc_s1_q, pgc_s2_q, pgd_s1_q, pgd_s2_q} <= 4'h0;
		end else begin
			{mclr_s1_q, mclr_s2_q, mclr_s3_q} <= {MASTER_CLEAR_HV_PIN_I, mclr_s1_q, mclr_s2_q};
			{pgc_s1_q, pgc_s2_q} <= {PROG_CLOCK_PIN_I, pgc_s1_q};
			{pgd_s1_q, pgd_s2_q} <= {PROG_DATA_PIN_I, pgd_s1_q};
		end
	end

	// a rise of master clear only counts when both link pins already sit high
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			mode_q <= 1'b0;
		end else if (!mclr_s2_q) begin
			mode_q <= 1'b0;
		end else if (!mclr_s3_q && pgc_s2_q && pgd_s2_q) begin
			mode_q <= 1'b1;
		end
	end

	// unused pins float for as long as the session lasts
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			UNUSED_PINS_HIZ_O <= 1'b0;
		end else begin
			UNUSED_PINS_HIZ_O <= mode_q;
		end
	end

	// ==========================================================
	// link side (programming clock domain)
	spe_link_e lst_q;
	logic run_s1_q, run_s2_q, rsp_s1_q, rsp_s2_q, rsp_seen_q;
	logic rx_tgl_q;
	logic [15:0] lsh_q, rx_word_q, rsp_word_q;
	logic [4:0] lcnt_q;
	logic rsp_tgl_q;

	// the link clock only runs in frames, so these settle over the first two edges
	always_ff @(posedge PROG_CLOCK_PIN_I) begin
		{run_s1_q, run_s2_q} <= {mode_q, run_s1_q};
		{rsp_s1_q, rsp_s2_q} <= {rsp_tgl_q, rsp_s1_q};
	end

	// sample on rising edges; after each word drive busy zeros, a one, then the answer
	always_ff @(posedge PROG_CLOCK_PIN_I) begin
		if (!run_s2_q) begin
			lst_q <= L_RX;
			lcnt_q <= 5'h00;
			lsh_q <= 16'h0000;
			rx_word_q <= 16'h0000;
			rx_tgl_q <= 1'b0;
			rsp_seen_q <= rsp_s2_q;  // keeps a stale toggle from looking new
			PROG_DATA_PIN_O <= 1'b0;
			PROG_DATA_PIN_OE_O <= 1'b0;
		end else begin
			case (lst_q)
				L_RX: begin
					lsh_q <= {lsh_q[14:0], PROG_DATA_PIN_I};
					lcnt_q <= lcnt_q + 5'h01;
					if (lcnt_q == LINK_LAST_BIT) begin
						rx_word_q <= {lsh_q[14:0], PROG_DATA_PIN_I};
						rx_tgl_q <= ~rx_tgl_q;
						lst_q <= L_WAIT;
						PROG_DATA_PIN_O <= 1'b0;
						PROG_DATA_PIN_OE_O <= 1'b1;
					end
				end
				L_WAIT: begin
					if (rsp_s2_q != rsp_seen_q) begin
						rsp_seen_q <= rsp_s2_q;
						lsh_q <= rsp_word_q;  // held stable by the sequencer
						lcnt_q <= 5'h00;
						PROG_DATA_PIN_O <= 1'b1;
						lst_q <= L_TX;
					end
				end
				L_TX: begin
					if (lcnt_q == LINK_TX_DONE) begin
						lcnt_q <= 5'h00;
						PROG_DATA_PIN_O <= 1'b0;
						PROG_DATA_PIN_OE_O <= 1'b0;
						lst_q <= L_RX;
					end else begin
						PROG_DATA_PIN_O <= lsh_q[15];
						lsh_q <= {lsh_q[14:0], 1'b0};
						lcnt_q <= lcnt_q + 5'h01;
					end
				end
				default: begin
					lst_q <= L_RX;
				end
			endcase
		end
	end

	// ==========================================================
	// word arrival crossing into the system clock
	logic rxt_s1_q, rxt_s2_q, rx_seen_q;
	logic lnk_s1_q, lnk_s2_q, lnk_s3_q;
	logic rx_new;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			{rxt_s1_q, rxt_s2_q, rx_seen_q} <= 3'h0;
		end else begin
			{rxt_s1_q, rxt_s2_q, rx_seen_q} <= {rx_tgl_q, rxt_s1_q, rxt_s2_q};
		end
	end

	// link-running flag, one stage longer than the toggle path, so a toggle flipped by
	// the link's own reset after entry lands while this still reads low
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			{lnk_s1_q, lnk_s2_q, lnk_s3_q} <= 3'h0;
		end else begin
			{lnk_s1_q, lnk_s2_q, lnk_s3_q} <= {run_s2_q, lnk_s1_q, lnk_s2_q};
		end
	end

	assign rx_new = mode_q && lnk_s3_q && (rxt_s2_q != rx_seen_q);

	// ==========================================================
	// array and its access steering; the executive itself lives in none of it
	spe_mem_if #(.AW(AW), .DW(16)) mbus ();

	spe_mem #(.AW(AW), .DW(16)) u_mem (
		.clk_i(SYS_CLK_I),
		.bus(mbus.mem)
	);

	spe_cmd_e st_q;
	logic [AW-1:0] ptr_q, end_q;
	logic [15:0] data_q;
	logic [ROW_LG-1:0] cnt_q, last_q;
	logic [3:0] op_q;
	logic fail_q, blank_q, mismatch, ers_ok;
	logic [1:0] w_sp, ptr_sp;
	logic [IDX_W-1:0] w_idx, ptr_idx;
	logic [15:0] devid_word;

	assign w_sp = rx_word_q[SP_MSB:SP_LSB];
	assign w_idx = rx_word_q[IDX_W-1:0];
	assign ptr_sp = ptr_q[AW-1 -: 2];
	assign ptr_idx = ptr_q[IDX_W-1:0];
	assign mismatch = mbus.rdata != data_q;
	assign ers_ok = (ptr_sp != SP_CFG) || (ptr_idx == IDX_CP);
	assign devid_word = (ptr_idx == '0) ? DEV_ID : ((ptr_idx == IDX_W'(1)) ? APP_ID : 16'h0000);

	// flash cells only clear on programming; config words take the value whole
	always_comb begin
		mbus.en = 1'b0;
		mbus.we = 1'b0;
		mbus.addr = ptr_q;
		mbus.wdata = ERASED_WORD;
		case (st_q)
			S_RDI, S_RD, S_VR, S_BRD: begin
				mbus.en = 1'b1;
			end
			S_WR: begin
				mbus.en = 1'b1;
				mbus.we = 1'b1;
				mbus.wdata = (ptr_sp == SP_CFG) ? data_q : (mbus.rdata & data_q);
			end
			S_ERS: begin
				mbus.en = 1'b1;
				mbus.we = ers_ok;
				mbus.wdata = ERASED_WORD;
			end
			default: begin
				mbus.en = 1'b0;
			end
		endcase
	end

	// visible activity: one toggle per array write
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			SERIAL_OUT_PIN_ONE_O <= 1'b0;
		end else if (mbus.we) begin
			SERIAL_OUT_PIN_ONE_O <= ~SERIAL_OUT_PIN_ONE_O;
		end
	end

	// ==========================================================
	// command sequencer; row data and pointers are scratch, left holding their values at exit
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			st_q <= S_IDLE;
			{ptr_q, end_q} <= '0;
			{data_q, rsp_word_q} <= 32'h0000_0000;
			{cnt_q, last_q} <= '0;
			op_q <= OP_SANITY;
			{fail_q, blank_q, rsp_tgl_q} <= 3'h0;
		end else if (!mode_q) begin
			st_q <= S_IDLE;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (rx_new) begin
						op_q <= rx_word_q[OP_MSB:OP_LSB];
						cnt_q <= '0;
						last_q <= ROW_ONES;
						fail_q <= 1'b0;
						case (rx_word_q[OP_MSB:OP_LSB])
							OP_SANITY: begin
								rsp_word_q <= {RSP_PASS, OP_SANITY, NO_PAYLOAD};
								rsp_tgl_q <= ~rsp_tgl_q;
							end
							OP_VERSION_QUERY: begin
								rsp_word_q <= {RSP_PASS, OP_VERSION_QUERY, VERSION_PAYLOAD};
								rsp_tgl_q <= ~rsp_tgl_q;
							end
							OP_READ_CODE: begin
								ptr_q <= {SP_CODE, w_idx};
								st_q <= S_RDI;
							end
							OP_READ_DATA: begin
								if (w_sp == SP_CODE) begin
									rsp_word_q <= {RSP_NACK, OP_READ_DATA, NO_PAYLOAD};
									rsp_tgl_q <= ~rsp_tgl_q;
								end else begin
									ptr_q <= {w_sp, w_idx};
									st_q <= S_RDI;
								end
							end
							OP_WRITE_CODE_ROW, OP_WRITE_DATA_ROW: begin
								ptr_q[AW-1 -: 2] <= (rx_word_q[OP_MSB:OP_LSB] == OP_WRITE_CODE_ROW)
									? SP_CODE : SP_EE;
								ptr_q[IDX_W-1:0] <= {w_idx[IDX_W-1:ROW_LG], ROW_ZERO};
								rsp_word_q <= {RSP_ACK, rx_word_q[OP_MSB:OP_LSB], NO_PAYLOAD};
								rsp_tgl_q <= ~rsp_tgl_q;
								st_q <= S_DATA;
							end
							OP_WRITE_CONFIG: begin
								ptr_q <= {SP_CFG, w_idx};
								last_q <= '0;
								rsp_word_q <= {RSP_ACK, OP_WRITE_CONFIG, NO_PAYLOAD};
								rsp_tgl_q <= ~rsp_tgl_q;
								st_q <= S_DATA;
							end
							OP_BULK_ERASE: begin
								case (w_sp)
									MS_ALL: begin
										ptr_q <= {SP_CODE, {IDX_W{1'b0}}};
										end_q <= {SP_CFG, IDX_CP};
									end
									MS_CODE: begin
										ptr_q <= {SP_CODE, {IDX_W{1'b0}}};
										end_q <= {SP_CODE, IDX_ONES};
									end
									MS_EE: begin
										ptr_q <= {SP_EE, {IDX_W{1'b0}}};
										end_q <= {SP_EE, IDX_ONES};
									end
									default: begin
										ptr_q <= {SP_CFG, IDX_CP};
										end_q <= {SP_CFG, IDX_CP};
									end
								endcase
								st_q <= S_ERS;
							end
							OP_ERASE_CODE, OP_ERASE_DATA: begin
								ptr_q[AW-1 -: 2] <= (rx_word_q[OP_MSB:OP_LSB] == OP_ERASE_CODE)
									? SP_CODE : SP_EE;
								end_q[AW-1 -: 2] <= (rx_word_q[OP_MSB:OP_LSB] == OP_ERASE_CODE)
									? SP_CODE : SP_EE;
								ptr_q[IDX_W-1:0] <= {w_idx[IDX_W-1:ROW_LG], ROW_ZERO};
								end_q[IDX_W-1:0] <= {w_idx[IDX_W-1:ROW_LG], ROW_ONES};
								st_q <= S_ERS;
							end
							OP_BLANK_QUERY: begin
								ptr_q <= {SP_CODE, {IDX_W{1'b0}}};
								end_q <= {SP_EE, IDX_ONES};
								blank_q <= 1'b1;
								st_q <= S_BRD;
							end
							default: begin
								rsp_word_q <= {RSP_NACK, rx_word_q[OP_MSB:OP_LSB], NO_PAYLOAD};
								rsp_tgl_q <= ~rsp_tgl_q;
							end
						endcase
					end
				end
				S_RDI: begin
					st_q <= S_RDO;
				end
				S_RDO: begin
					rsp_word_q <= (ptr_sp == SP_DEVID) ? devid_word : mbus.rdata;
					rsp_tgl_q <= ~rsp_tgl_q;
					st_q <= S_IDLE;
				end
				S_DATA: begin
					if (rx_new) begin
						data_q <= rx_word_q;
						st_q <= S_RD;
					end
				end
				S_RD: begin
					st_q <= S_WR;
				end
				S_WR: begin
					st_q <= S_VR;
				end
				S_VR: begin
					st_q <= S_CHK;
				end
				S_CHK: begin
					// read-back compare decides pass or fail for the whole row
					if (cnt_q == last_q) begin
						rsp_word_q <= {(fail_q || mismatch) ? RSP_FAIL : RSP_PASS, op_q, NO_PAYLOAD};
						st_q <= S_IDLE;
					end else begin
						rsp_word_q <= {RSP_ACK, op_q, NO_PAYLOAD};
						st_q <= S_DATA;
					end
					rsp_tgl_q <= ~rsp_tgl_q;
					fail_q <= fail_q || mismatch;
					cnt_q <= cnt_q + ROW_LG'(1);
					ptr_q <= ptr_q + AW'(1);
				end
				S_ERS: begin
					if (ptr_q == end_q) begin
						rsp_word_q <= {RSP_PASS, op_q, NO_PAYLOAD};
						rsp_tgl_q <= ~rsp_tgl_q;
						st_q <= S_IDLE;
					end else begin
						ptr_q <= ptr_q + AW'(1);
					end
				end
				S_BRD: begin
					st_q <= S_BCHK;
				end
				S_BCHK: begin
					if (ptr_q == end_q) begin
						rsp_word_q <= {(blank_q && mbus.rdata == ERASED_WORD)
							? RSP_BLANK : RSP_NOT_BLANK, OP_BLANK_QUERY, NO_PAYLOAD};
						rsp_tgl_q <= ~rsp_tgl_q;
						st_q <= S_IDLE;
					end else begin
						blank_q <= blank_q && (mbus.rdata == ERASED_WORD);
						ptr_q <= ptr_q + AW'(1);
						st_q <= S_BRD;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule : spe_top

// ### rtl/spe_pkg.sv
// constants, opcodes and state types for the serial programming executive
package spe_pkg;
	// ==========================================================
	// link word layout
	localparam int LINK_BITS = 16;
	localparam logic [4:0] LINK_LAST_BIT = 5'h0f;
	localparam logic [4:0] LINK_TX_DONE = 5'h10;
	localparam int OP_MSB = 15;
	localparam int OP_LSB = 12;
	localparam int SP_MSB = 11;
	localparam int SP_LSB = 10;
	// ==========================================================
	// command opcodes
	localparam logic [3:0] OP_SANITY = 4'h0;
	localparam logic [3:0] OP_READ_DATA = 4'h1;
	localparam logic [3:0] OP_READ_CODE = 4'h2;
	localparam logic [3:0] OP_WRITE_DATA_ROW = 4'h3;
	localparam logic [3:0] OP_WRITE_CODE_ROW = 4'h4;
	localparam logic [3:0] OP_WRITE_CONFIG = 4'h5;
	localparam logic [3:0] OP_BULK_ERASE = 4'h6;
	localparam logic [3:0] OP_ERASE_DATA = 4'h7;
	localparam logic [3:0] OP_ERASE_CODE = 4'h8;
	localparam logic [3:0] OP_BLANK_QUERY = 4'h9;
	localparam logic [3:0] OP_VERSION_QUERY = 4'ha;
	// ==========================================================
	// memory spaces, also the memory_select_field codes of bulk erase
	localparam logic [1:0] SP_CODE = 2'h0;
	localparam logic [1:0] SP_EE = 2'h1;
	localparam logic [1:0] SP_CFG = 2'h2;
	localparam logic [1:0] SP_DEVID = 2'h3;
	localparam logic [1:0] MS_CP_ONLY = 2'h0;
	localparam logic [1:0] MS_CODE = 2'h1;
	localparam logic [1:0] MS_EE = 2'h2;
	localparam logic [1:0] MS_ALL = 2'h3;
	localparam int CFG_CP_IDX = 6;
	localparam int ROW_LG = 2;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// ==========================================================
	// response codes, upper nibble of a status response
	localparam logic [3:0] RSP_PASS = 4'h1;
	localparam logic [3:0] RSP_FAIL = 4'h2;
	localparam logic [3:0] RSP_NACK = 4'h3;
	localparam logic [3:0] RSP_ACK = 4'h4;
	localparam logic [3:0] RSP_BLANK = 4'h5;
	localparam logic [3:0] RSP_NOT_BLANK = 4'h6;
	localparam logic [7:0] VERSION_PAYLOAD = 8'h10;
	localparam logic [7:0] NO_PAYLOAD = 8'h00;
	// ==========================================================
	// state types
	typedef enum logic [1:0] {L_RX, L_WAIT, L_TX} spe_link_e;
	typedef enum logic [3:0] {
		S_IDLE, S_RDI, S_RDO, S_DATA, S_RD, S_WR, S_VR, S_CHK, S_ERS, S_BRD, S_BCHK
	} spe_cmd_e;
endpackage : spe_pkg

// ### rtl/spe_mem_if.sv
// port bundle between the command sequencer and the nonvolatile array
`timescale 1ns/1ps
interface spe_mem_if #(parameter int AW = 7, parameter int DW = 16);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : spe_mem_if

// ### rtl/spe_mem.sv
// nonvolatile array model: code, data eeprom and config spaces, registered read
`timescale 1ns/1ps
module spe_mem #(
	parameter int AW = 7,
	parameter int DW = 16
) (
	input wire logic clk_i,
	spe_mem_if.mem bus
);
	logic [DW-1:0] array_q [2**AW];

	// ==========================================================
	// one access per cycle; read data comes from a register
	always_ff @(posedge clk_i) begin
		if (bus.en && bus.we) begin
			array_q[bus.addr] <= bus.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (bus.en) begin
			bus.rdata <= array_q[bus.addr];
		end
	end
endmodule : spe_mem

// ### sim/spe_top_asserts.sv
// concurrent checks on the pins of the serial programming executive
`timescale 1ns/1ps
module spe_top_asserts (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic PROG_CLOCK_PIN_I,
	input wire logic PROG_DATA_PIN_I,
	input wire logic PROG_DATA_PIN_O,
	input wire logic PROG_DATA_PIN_OE_O,
	input wire logic MASTER_CLEAR_HV_PIN_I,
	input wire logic SERIAL_OUT_PIN_ONE_O,
	input wire logic UNUSED_PINS_HIZ_O
);
	// ==========================================================
	// mode entry, exit and activity pin, system clock domain
	hiz_entry_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		$rose(MASTER_CLEAR_HV_PIN_I) && PROG_CLOCK_PIN_I && PROG_DATA_PIN_I
		|-> ##[1:8] UNUSED_PINS_HIZ_O) else $error("pins not floated after entry");
	hiz_exit_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		$fell(MASTER_CLEAR_HV_PIN_I) |-> ##[1:6] !UNUSED_PINS_HIZ_O)
		else $error("pins still floated after exit");
	hiz_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		UNUSED_PINS_HIZ_O && MASTER_CLEAR_HV_PIN_I |=> UNUSED_PINS_HIZ_O)
		else $error("pins left floating state during session");
	reset_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		$rose(RST_B_I) |-> !UNUSED_PINS_HIZ_O && !SERIAL_OUT_PIN_ONE_O)
		else $error("outputs not quiet after reset");
	toggle_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		$changed(SERIAL_OUT_PIN_ONE_O) |-> $past(UNUSED_PINS_HIZ_O))
		else $error("activity pin moved outside a session");
	// ==========================================================
	// response framing, link clock domain; link logic is held while master clear is low
	busy_first_a: assert property (@(posedge PROG_CLOCK_PIN_I)
		disable iff (!MASTER_CLEAR_HV_PIN_I)
		$rose(PROG_DATA_PIN_OE_O) |-> !PROG_DATA_PIN_O) else $error("no busy level");
	oe_hold_a: assert property (@(posedge PROG_CLOCK_PIN_I)
		disable iff (!MASTER_CLEAR_HV_PIN_I)
		$rose(PROG_DATA_PIN_OE_O) |-> PROG_DATA_PIN_OE_O[*8] ##1 PROG_DATA_PIN_OE_O[*8])
		else $error("data pin released too early");
	frame_shape_a: assert property (@(posedge PROG_CLOCK_PIN_I)
		disable iff (!MASTER_CLEAR_HV_PIN_I)
		$fell(PROG_DATA_PIN_OE_O) |-> $past(PROG_DATA_PIN_OE_O, 18)
		&& $past(PROG_DATA_PIN_O, 17) && !$past(PROG_DATA_PIN_O, 18))
		else $error("response not start bit plus sixteen bits");
endmodule : spe_top_asserts

bind spe_top spe_top_asserts spe_top_asserts_i (
	.SYS_CLK_I,
	.RST_B_I,
	.PROG_CLOCK_PIN_I,
	.PROG_DATA_PIN_I,
	.PROG_DATA_PIN_O,
	.PROG_DATA_PIN_OE_O,
	.MASTER_CLEAR_HV_PIN_I,
	.SERIAL_OUT_PIN_ONE_O,
	.UNUSED_PINS_HIZ_O
);

// ### sim/spe_host_model.sv
// programmer model driving the link pins and master clear
`timescale 1ns/1ps
module spe_host_model (
	input wire logic dev_d_i,
	input wire logic dev_oe_i,
	output logic clk_o,
	output logic data_o,
	output logic mclr_o
);
	logic drive = 1'b1;
	logic level = 1'b1;
	// device wins the wire while it drives; a released wire shows a moving pattern
	assign data_o = dev_oe_i ? dev_d_i : level;
	initial begin
		clk_o = 1'b1;
		mclr_o = 1'b0;
	end
	// one link clock: fall, host moves data, rise samples; stands high between frames
	task automatic tick(input logic b);
		clk_o = 1'b0;
		level = drive ? b : ~level;
		#15 clk_o = 1'b1;
		#15;
	endtask : tick
	// pins high first, then master clear; the small offset keeps edges off the system clock
	// three ticks: the link run flag needs two edges to be known, the third resets the link
	task automatic enter();
		#3;
		drive = 1'b1;
		tick(1'b1);
		tick(1'b1);
		tick(1'b1);
		#100 mclr_o = 1'b1;
		#300;
		tick(1'b1);
		tick(1'b1);
	endtask : enter
	task automatic leave();
		mclr_o = 1'b0;
		#200;
	endtask : leave
	// one word out, msb first, then one response back; ok is low on a hang
	task automatic word(input logic [15:0] w, output logic [15:0] r, output logic ok);
		int n;
		drive = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			tick(w[i]);
		end
		drive = 1'b0;
		n = 0;
		while (data_o !== 1'b1 && n < 400) begin
			tick(1'b0);
			n++;
		end
		for (int i = 15; i >= 0; i--) begin
			tick(1'b0);
			r[i] = data_o;
		end
		tick(1'b0);
		ok = (n < 400) && (dev_oe_i === 1'b0);
	endtask : word
endmodule : spe_host_model

// ### sim/tb_top.sv
// self-checking bench for the serial programming executive
`timescale 1ns/1ps
module tb_top;
	import spe_pkg::*;
	localparam logic [15:0] DEV_ID = 16'h5a01;  // arbitrary value
	localparam logic [15:0] APP_ID = 16'h00c3;  // arbitrary value
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic pclk, pdat, mclr, dout, doe, sdo, hiz;
	int num_errors = 0;
	int comparisons = 0;
	int toggles = 0;
	// ==========================================================
	// clock, design and programmer
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	spe_top #(.DEV_ID(DEV_ID), .APP_ID(APP_ID)) spe_top_i (
		.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .PROG_CLOCK_PIN_I(pclk),
		.PROG_DATA_PIN_I(pdat), .PROG_DATA_PIN_O(dout), .PROG_DATA_PIN_OE_O(doe),
		.MASTER_CLEAR_HV_PIN_I(mclr), .SERIAL_OUT_PIN_ONE_O(sdo), .UNUSED_PINS_HIZ_O(hiz)
	);
	spe_host_model spe_host_model_i (
		.dev_d_i(dout), .dev_oe_i(doe), .clk_o(pclk), .data_o(pdat), .mclr_o(mclr)
	);
	// activity pin edges, counted so a scenario can see programming was visible
	always @(sdo) toggles++;
	// ==========================================================
	// helpers
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// a hung link ends the run at once
	task automatic cmd(input logic [15:0] w, input logic [15:0] exp);
		logic [15:0] r;
		logic ok;
		spe_host_model_i.word(w, r, ok);
		if (!ok) begin
			num_errors++;
			$display("wrong value at %0t: no response", $time);
			test_done();
		end else begin
			check(r, exp);
		end
	endtask : cmd
	function automatic logic [15:0] cw(input logic [3:0] op, input logic [1:0] sp,
			input logic [4:0] ix);
		return {op, sp, 5'h00, ix};
	endfunction : cw
	function automatic logic [15:0] st(input logic [3:0] c, input logic [3:0] op);
		return {c, op, NO_PAYLOAD};
	endfunction : st
	// row write: command and three words acknowledged, fourth gets the verdict
	task automatic row(input logic [3:0] op, input logic [1:0] sp, input logic [4:0] ix,
			input logic [15:0] v, input logic [3:0] fin);
		cmd(cw(op, sp, ix), st(RSP_ACK, op));
		for (int k = 0; k < 3; k++) begin
			cmd(v ^ 16'(k), st(RSP_ACK, op));
		end
		cmd(v ^ 16'h0003, st(fin, op));
	endtask : row
	// ==========================================================
	// scenarios
	task automatic t_query();
		cmd(cw(OP_SANITY, 2'h0, 5'h00), st(RSP_PASS, OP_SANITY));
		cmd(cw(OP_VERSION_QUERY, 2'h0, 5'h00), {RSP_PASS, OP_VERSION_QUERY, VERSION_PAYLOAD});
		for (int op = 11; op < 16; op++) begin
			cmd(cw(4'(op), 2'h0, 5'h00), st(RSP_NACK, 4'(op)));
		end
		cmd(cw(OP_READ_DATA, SP_DEVID, 5'h01), APP_ID);
		cmd(cw(OP_READ_DATA, SP_DEVID, 5'h00), DEV_ID);
		cmd(cw(OP_READ_DATA, SP_CODE, 5'h00), st(RSP_NACK, OP_READ_DATA));
	endtask : t_query
	task automatic t_erase();
		int t0;
		t0 = toggles;
		cmd(cw(OP_BULK_ERASE, MS_ALL, 5'h00), st(RSP_PASS, OP_BULK_ERASE));
		check(16'(toggles != t0), 16'h0001);
		cmd(cw(OP_BLANK_QUERY, 2'h0, 5'h00), st(RSP_BLANK, OP_BLANK_QUERY));
		cmd(cw(OP_READ_CODE, SP_CODE, 5'h1f), ERASED_WORD);
		cmd(cw(OP_READ_DATA, SP_EE, 5'h00), ERASED_WORD);
		cmd(cw(OP_READ_DATA, SP_CFG, 5'(CFG_CP_IDX)), ERASED_WORD);
	endtask : t_erase
	// programming a one over a zero cannot verify, so the second row write fails
	task automatic t_code();
		row(OP_WRITE_CODE_ROW, SP_CODE, 5'h05, 16'h3c5a, RSP_PASS);
		for (int k = 0; k < 4; k++) begin
			cmd(cw(OP_READ_CODE, SP_CODE, 5'(4 + k)), 16'h3c5a ^ 16'(k));
		end
		cmd(cw(OP_BLANK_QUERY, 2'h0, 5'h00), st(RSP_NOT_BLANK, OP_BLANK_QUERY));
		row(OP_WRITE_CODE_ROW, SP_CODE, 5'h04, 16'hffff, RSP_FAIL);
		cmd(cw(OP_ERASE_CODE, SP_CODE, 5'h06), st(RSP_PASS, OP_ERASE_CODE));
		cmd(cw(OP_READ_CODE, SP_CODE, 5'h04), ERASED_WORD);
	endtask : t_code
	task automatic t_data();
		row(OP_WRITE_DATA_ROW, SP_EE, 5'h0b, 16'h0f0f, RSP_PASS);
		cmd(cw(OP_READ_DATA, SP_EE, 5'h0a), 16'h0f0d);
		cmd(cw(OP_WRITE_CONFIG, SP_CFG, 5'h02), st(RSP_ACK, OP_WRITE_CONFIG));
		cmd(16'h00c0, st(RSP_PASS, OP_WRITE_CONFIG));
		cmd(cw(OP_ERASE_DATA, SP_EE, 5'h08), st(RSP_PASS, OP_ERASE_DATA));
		cmd(cw(OP_READ_DATA, SP_EE, 5'h0a), ERASED_WORD);
		for (int ms = 0; ms < 3; ms++) begin
			cmd(cw(OP_BULK_ERASE, 2'(ms), 5'h00), st(RSP_PASS, OP_BULK_ERASE));
		end
		cmd(cw(OP_READ_DATA, SP_CFG, 5'h02), 16'h00c0);
		cmd(cw(OP_READ_DATA, SP_DEVID, 5'h00), DEV_ID);
	endtask : t_data
	task automatic t_exit();
		check(16'(hiz), 16'h0001);
		// clock switch field, bits 7:6 of config word 2, reads 11 before the next entry
		cmd(cw(OP_READ_DATA, SP_CFG, 5'h02), 16'h00c0);
		spe_host_model_i.leave();
		check(16'(hiz), 16'h0000);
		spe_host_model_i.enter();
		check(16'(hiz), 16'h0001);
		cmd(cw(OP_SANITY, 2'h0, 5'h00), st(RSP_PASS, OP_SANITY));
	endtask : t_exit
	// ==========================================================
	// main sequence: erase and check blank before any programming
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		spe_host_model_i.enter();
		t_query();
		t_erase();
		t_code();
		t_data();
		t_exit();
		test_done();
	end
endmodule : tb_top
